// >>> core/remote_access_fsm.sv
`timescale 1ns/1ns
// Overview of operation
// - stay idle until host access enable and host read strobe are both active.
// - request while locked out or with a local bus request goes to hold until both clear.
// - in idle or hold with bus lock high, grant local bus requests.
// - drive acknowledge low as soon as a remote read request appears.
// - unlocked and no local request: enter takeover the clock after the request.
// - no local grant from takeover until termination; local access waits meanwhile.
// - half a T-state into takeover float address bus, and data bus for data memory.
// - next clock raise bus owner, keep ack low, load wait counters from config.
// - command select high reads config register, the default data bus source.
// - memory select 10 or 11 returns low or high program counter byte.
// - select 00 asserts data read strobe, buses float, waits data wait states.
// - select 01 returns low or high instruction byte per flag, instruction waits.
// - high-byte flag cleared by reset and by writing 01 to memory select.
// - wait input low before last programmed wait ends extends access indefinitely.
// - after waits with wait high enter termination, ack high, buses float.
// - read strobe held half T-state after ack rises; owner falls half later.
// - owner low next clock, buses float half T-state, then local grants resume.
// - after instruction read toggle high-byte flag; increment PC if high byte.
// - request gone returns to idle next clock, else trail until it goes.
// - data read strobe after one T-state settle; ack after plus data waits.
// - one T-state takeover delay so local read strobe ends before ownership switch.
module remote_access_fsm (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_host_access_enable,
    input wire logic i_host_read_strobe_n,
    input wire logic i_cmd_select,
    input wire logic i_wait_n,
    input wire logic i_lock_n,
    input wire logic i_lock_out_remote_bit,
    input wire logic [1:0] i_memory_select_field,
    input wire logic i_memory_select_wr,
    input wire logic [1:0] i_instr_wait_field,
    input wire logic [2:0] i_data_wait_field,
    input wire logic i_local_bus_request,
    input wire logic [7:0] i_host_interface_config_reg,
    input wire logic [15:0] i_program_counter,
    input wire logic [15:0] i_instr_word,
    output logic o_local_bus_grant,
    output logic o_remote_wait_tstate,
    output logic o_transfer_acknowledge,
    output logic o_local_bus_owner_n,
    output logic o_addr_oe,
    output logic o_ad_oe,
    output logic [7:0] o_ad_out,
    output logic o_data_read_n,
    output logic o_high_byte_flag,
    output logic o_pc_increment,
    output logic [15:0] o_pc_next
);
    // one T-state is one i_clk cycle; half T-states use the falling edge
    remote_read_pkg::fsm_state_t state_q, state_d;
    logic [2:0] sync_q;
    logic host_en_s, host_rd_n_s, wait_n_s;
    logic req;
    logic [2:0] wait_cnt_q;
    logic [1:0] target_q;
    logic cmd_q;
    logic high_byte_q;
    logic [7:0] ad_q;
    logic term_hold_q;
    logic release_hold_q;
    logic read_strobe_n_q;
    logic float_ad_q;

    pin_sync #(.WIDTH(3)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_host_access_enable, i_host_read_strobe_n, i_wait_n}),
        .o_sync(sync_q)
    );
    assign host_en_s = sync_q[2];
    assign host_rd_n_s = sync_q[1];
    assign wait_n_s = sync_q[0];
    assign req = host_en_s && !host_rd_n_s;

    function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic hi);
        pick_byte = hi ? word[15:8] : word[7:0];
    endfunction : pick_byte

    logic waits_done;
    assign waits_done = (wait_cnt_q == remote_read_pkg::WAIT_ZERO) && wait_n_s;

    always_comb begin
        state_d = state_q;
        case (state_q)
            remote_read_pkg::ST_IDLE, remote_read_pkg::ST_HOLD: begin
                if (!req) begin
                    state_d = remote_read_pkg::ST_IDLE;
                end else if (i_lock_out_remote_bit || i_local_bus_request) begin
                    state_d = remote_read_pkg::ST_HOLD;
                end else begin
                    state_d = remote_read_pkg::ST_TAKEOVER;
                end
            end
            remote_read_pkg::ST_TAKEOVER: state_d = remote_read_pkg::ST_SETUP;
            remote_read_pkg::ST_SETUP: state_d = remote_read_pkg::ST_ACCESS;
            remote_read_pkg::ST_ACCESS: begin
                if (waits_done) begin
                    state_d = remote_read_pkg::ST_TERM;
                end
            end
            remote_read_pkg::ST_TERM: state_d = remote_read_pkg::ST_RELEASE;
            remote_read_pkg::ST_RELEASE, remote_read_pkg::ST_TRAIL: begin
                // the host's trailing edge is not awaited before handing back the buses
                state_d = req ? remote_read_pkg::ST_TRAIL : remote_read_pkg::ST_IDLE;
            end
            default: state_d = remote_read_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= remote_read_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // access target captured in takeover; select field is stable over the access
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_cnt_q <= remote_read_pkg::WAIT_ZERO;
            target_q <= remote_read_pkg::MS_DATA;
            cmd_q <= 1'b0;
        end else if (state_q == remote_read_pkg::ST_TAKEOVER) begin
            cmd_q <= i_cmd_select;
            target_q <= i_memory_select_field;
            if (!i_cmd_select && i_memory_select_field == remote_read_pkg::MS_DATA) begin
                wait_cnt_q <= i_data_wait_field;
            end else if (!i_cmd_select && i_memory_select_field == remote_read_pkg::MS_INSTR) begin
                wait_cnt_q <= {1'b0, i_instr_wait_field};
            end else begin
                wait_cnt_q <= remote_read_pkg::WAIT_ZERO;
            end
        end else if (state_q == remote_read_pkg::ST_ACCESS && wait_cnt_q != remote_read_pkg::WAIT_ZERO) begin
            wait_cnt_q <= wait_cnt_q - remote_read_pkg::WAIT_ONE;
        end
    end

    // data bus source: config register by default, PC or instruction byte by target
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ad_q <= 8'h00;
        end else if (state_q == remote_read_pkg::ST_SETUP && !cmd_q) begin
            if (target_q == remote_read_pkg::MS_PC_LOW) begin
                ad_q <= pick_byte(i_program_counter, 1'b0);
            end else if (target_q == remote_read_pkg::MS_PC_HIGH) begin
                ad_q <= pick_byte(i_program_counter, 1'b1);
            end else if (target_q == remote_read_pkg::MS_INSTR) begin
                ad_q <= pick_byte(i_instr_word, high_byte_q);
            end else begin
                ad_q <= i_host_interface_config_reg;
            end
        end else if (state_q == remote_read_pkg::ST_IDLE || state_q == remote_read_pkg::ST_HOLD) begin
            ad_q <= i_host_interface_config_reg;
        end
    end

    logic instr_done;
    assign instr_done = state_q == remote_read_pkg::ST_TERM && !cmd_q && target_q == remote_read_pkg::MS_INSTR;

    // clearing on a select write beats the toggle, realigning the word boundary
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            high_byte_q <= 1'b0;
        end else if (i_memory_select_wr && i_memory_select_field == remote_read_pkg::MS_INSTR) begin
            high_byte_q <= 1'b0;
        end else if (instr_done) begin
            high_byte_q <= !high_byte_q;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pc_increment <= 1'b0;
            o_pc_next <= remote_read_pkg::PC_RESET;
        end else begin
            o_pc_increment <= instr_done && high_byte_q;
            o_pc_next <= i_program_counter + remote_read_pkg::PC_STEP;
        end
    end

    // half T-state actions, registered on the falling edge
    always_ff @(negedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            term_hold_q <= 1'b0;
            release_hold_q <= 1'b0;
            read_strobe_n_q <= 1'b1;
            float_ad_q <= 1'b0;
        end else begin
            term_hold_q <= state_q == remote_read_pkg::ST_TERM;
            release_hold_q <= state_q == remote_read_pkg::ST_RELEASE;
            // strobe goes low in access and holds through the first half of termination
            read_strobe_n_q <= !(!cmd_q && target_q == remote_read_pkg::MS_DATA &&
                state_q == remote_read_pkg::ST_ACCESS);
            float_ad_q <= (state_q == remote_read_pkg::ST_TAKEOVER && !i_cmd_select &&
                i_memory_select_field == remote_read_pkg::MS_DATA) || (float_ad_q &&
                state_q != remote_read_pkg::ST_RELEASE && state_q != remote_read_pkg::ST_IDLE);
        end
    end

    logic remote_span;
    assign remote_span = state_q inside {remote_read_pkg::ST_TAKEOVER, remote_read_pkg::ST_SETUP,
        remote_read_pkg::ST_ACCESS, remote_read_pkg::ST_TERM};
    logic bus_float;
    assign bus_float = (remote_span && !(state_q == remote_read_pkg::ST_TAKEOVER && i_clk)) ||
        (state_q == remote_read_pkg::ST_RELEASE && i_clk);

    // grant is withheld from takeover through termination; float half of release first
    assign o_local_bus_grant = i_local_bus_request && !remote_span && !bus_float &&
        ((state_q != remote_read_pkg::ST_IDLE && state_q != remote_read_pkg::ST_HOLD) || i_lock_n);
    assign o_remote_wait_tstate = i_local_bus_request && remote_span;
    assign o_transfer_acknowledge = !(req && state_q inside {remote_read_pkg::ST_IDLE, remote_read_pkg::ST_HOLD,
        remote_read_pkg::ST_TAKEOVER, remote_read_pkg::ST_SETUP, remote_read_pkg::ST_ACCESS}) &&
        !(state_q inside {remote_read_pkg::ST_SETUP, remote_read_pkg::ST_ACCESS});
    // high while the remote side owns the buses; falls half a T-state after the strobe rises
    assign o_local_bus_owner_n = state_q inside {remote_read_pkg::ST_SETUP, remote_read_pkg::ST_ACCESS,
        remote_read_pkg::ST_TERM};
    assign o_addr_oe = !bus_float;
    assign o_ad_oe = !(bus_float && float_ad_q) && !(state_q == remote_read_pkg::ST_TAKEOVER && !i_clk &&
        float_ad_q);
    assign o_ad_out = ad_q;
    assign o_data_read_n = read_strobe_n_q;
    assign o_high_byte_flag = high_byte_q;

    a_ack_low_on_req: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == remote_read_pkg::ST_IDLE && req) |-> !o_transfer_acknowledge)
        else $error("ack not low on request");
    a_hold_when_locked: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == remote_read_pkg::ST_IDLE && req && i_lock_out_remote_bit) |=> state_q == remote_read_pkg::ST_HOLD)
        else $error("locked request did not hold");
    a_takeover_next: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == remote_read_pkg::ST_IDLE && req && !i_lock_out_remote_bit && !i_local_bus_request)
        |=> state_q == remote_read_pkg::ST_TAKEOVER ##1 state_q == remote_read_pkg::ST_SETUP)
        else $error("takeover sequence broken");
    a_owner_in_setup: assert property (@(posedge i_clk) disable iff (i_rst)
        state_q == remote_read_pkg::ST_SETUP |-> o_local_bus_owner_n && !o_transfer_acknowledge)
        else $error("setup outputs wrong");
    a_no_grant_remote: assert property (@(posedge i_clk) disable iff (i_rst)
        remote_span |-> !o_local_bus_grant)
        else $error("grant during remote access");
    a_ack_in_term: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == remote_read_pkg::ST_ACCESS && waits_done) |=> o_transfer_acknowledge && o_local_bus_owner_n)
        else $error("termination outputs wrong");
    a_wait_extends: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == remote_read_pkg::ST_ACCESS && !wait_n_s) |=> state_q == remote_read_pkg::ST_ACCESS)
        else $error("wait did not extend");
    a_flag_toggles: assert property (@(posedge i_clk) disable iff (i_rst)
        (instr_done && !i_memory_select_wr) |=> o_high_byte_flag != $past(high_byte_q))
        else $error("high byte flag not toggled");
    a_trail_or_idle: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == remote_read_pkg::ST_RELEASE && !req) |=> state_q == remote_read_pkg::ST_IDLE)
        else $error("release did not return idle");
endmodule : remote_access_fsm

// >>> shared/remote_read_pkg.sv
package remote_read_pkg;
    localparam int unsigned IW_W = 2;
    localparam int unsigned DW_W = 3;
    localparam int unsigned MS_W = 2;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned PC_W = 16;
    localparam int unsigned IWORD_W = 16;
    localparam logic [1:0] MS_DATA = 2'h0;
    localparam logic [1:0] MS_INSTR = 2'h1;
    localparam logic [1:0] MS_PC_LOW = 2'h2;
    localparam logic [1:0] MS_PC_HIGH = 2'h3;
    localparam logic [7:0] BYTE_LOW_LSB = 8'h00;
    localparam logic [7:0] BYTE_HIGH_LSB = 8'h08;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [2:0] WAIT_ZERO = 3'h0;
    localparam logic [2:0] WAIT_ONE = 3'h1;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_HOLD,
        ST_TAKEOVER,
        ST_SETUP,
        ST_ACCESS,
        ST_TERM,
        ST_RELEASE,
        ST_TRAIL
    } fsm_state_t;
endpackage : remote_read_pkg

// >>> core/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    // the first stage feeds the second stage only
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : pin_sync

// >>> verif/remote_host_model.sv
`timescale 1ns/1ns
module remote_host_model (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [7:0] i_wait_len,
    input wire logic i_ack,
    input wire logic [7:0] i_ad,
    output logic o_enable,
    output logic o_strobe_n,
    output logic o_wait_n,
    output logic o_busy,
    output logic [7:0] o_data,
    output logic [8:0] o_cycles
);
    logic seen;
    initial begin
        o_enable = 1'b0;
        o_strobe_n = 1'b1;
        o_wait_n = 1'b1;
        o_busy = 1'b0;
        o_data = 8'h00;
        o_cycles = 9'h000;
    end
    always begin
        @(posedge i_clk iff i_go);
        #1;
        o_busy = 1'b1;
        o_enable = 1'b1;
        o_strobe_n = 1'b0;
        o_wait_n = (i_wait_len == 8'h00);
        o_cycles = 9'h000;
        seen = 1'b0;
        // request held until the edge that samples the rising ack; a stale high ack is ignored
        forever begin
            @(posedge i_clk);
            o_cycles = o_cycles + 9'h001;
            if (i_ack === 1'b0) seen = 1'b1;
            if ((seen && i_ack === 1'b1) || o_cycles == 9'h1ff) break;
            #1;
            if (o_cycles >= {1'b0, i_wait_len}) o_wait_n = 1'b1;
        end
        o_data = i_ad;
        #1;
        o_enable = 1'b0;
        o_strobe_n = 1'b1;
        o_busy = 1'b0;
    end
endmodule : remote_host_model

// >>> verif/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic clk, rst, cmd, lock_n, lock_out_remote_bit, msel_wr, lreq, go;
    logic [1:0] msel, iw;
    logic [2:0] dw;
    logic [7:0] cfg, wlen, ad_out, hdata;
    logic [15:0] pc, iword, pcnext;
    logic en, strn, waitn, busy, grant, twait, ack, own_n, aoe, adoe, rd_n, high_byte_flag;
    logic seen_rd, seen_float, pcinc, seen_inc;
    logic [8:0] hcyc, c0, c1;
    int num_errors = 0;
    int comparisons = 0;
    remote_access_fsm i_dut (.i_clk(clk), .i_rst(rst), .i_host_access_enable(en), .i_host_read_strobe_n(strn),
        .i_cmd_select(cmd), .i_wait_n(waitn), .i_lock_n(lock_n), .i_lock_out_remote_bit(lock_out_remote_bit),
        .i_memory_select_field(msel), .i_memory_select_wr(msel_wr), .i_instr_wait_field(iw),
        .i_data_wait_field(dw), .i_local_bus_request(lreq), .i_host_interface_config_reg(cfg),
        .i_program_counter(pc), .i_instr_word(iword), .o_local_bus_grant(grant), .o_remote_wait_tstate(twait),
        .o_transfer_acknowledge(ack), .o_local_bus_owner_n(own_n), .o_addr_oe(aoe), .o_ad_oe(adoe),
        .o_ad_out(ad_out), .o_data_read_n(rd_n), .o_high_byte_flag(high_byte_flag), .o_pc_increment(pcinc),
        .o_pc_next(pcnext));
    remote_host_model i_host (.i_clk(clk), .i_go(go), .i_wait_len(wlen), .i_ack(ack), .i_ad(ad_out),
        .o_enable(en), .o_strobe_n(strn), .o_wait_n(waitn), .o_busy(busy), .o_data(hdata), .o_cycles(hcyc));
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic stop_test;
        if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task automatic start_read(input logic c, input logic [1:0] s, input logic [7:0] w);
        cmd = c;
        msel = s;
        wlen = w;
        go = 1'b1;
        @(posedge clk);
        #1 go = 1'b0;
    endtask : start_read
    task automatic finish_read;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy && n < 600);
        // let the synchronised release reach idle before the next request
        repeat (6) @(posedge clk);
        #1;
    endtask : finish_read
    task automatic do_read(input logic c, input logic [1:0] s, input logic [7:0] w);
        start_read(c, s, w);
        finish_read();
    endtask : do_read
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (!rst) begin
        if (rd_n === 1'b0) seen_rd = 1'b1;
        if (pcinc === 1'b1) seen_inc = 1'b1;
        if (own_n === 1'b1 && aoe === 1'b0 && adoe === 1'b0) seen_float = 1'b1;
        if (own_n === 1'b1 && ack === 1'b0) check("grant_in_access", 16'h0000, {15'h0000, grant});
    end
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        stop_test();
    end
    initial begin
        {rst, cmd, lock_n, lock_out_remote_bit, msel_wr, lreq, go, seen_rd, seen_float} = 9'h140;
        seen_inc = 1'b0;
        {msel, iw, dw, wlen} = 15'h0000;
        cfg = 8'h5a;
        pc = 16'h12fe;
        iword = 16'ha53c;
        repeat (10) @(posedge clk);
        check("ack_reset", 16'h0001, {15'h0000, ack});
        check("flag_reset", 16'h0000, {15'h0000, high_byte_flag});
        check("rd_reset", 16'h0001, {15'h0000, rd_n});
        #1 rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        do_read(1'b1, remote_read_pkg::MS_PC_LOW, 8'h00);
        check("cfg_byte", {8'h00, cfg}, {8'h00, hdata});
        do_read(1'b0, remote_read_pkg::MS_PC_LOW, 8'h00);
        check("pc_low", {8'h00, pc[7:0]}, {8'h00, hdata});
        do_read(1'b0, remote_read_pkg::MS_PC_HIGH, 8'h00);
        check("pc_high", {8'h00, pc[15:8]}, {8'h00, hdata});
        do_read(1'b0, remote_read_pkg::MS_INSTR, 8'h00);
        c0 = hcyc;
        check("instr_low", 16'h003c, {8'h00, hdata});
        check("flag_set", 16'h0001, {15'h0000, high_byte_flag});
        msel_wr = 1'b1;
        @(posedge clk);
        #1 msel_wr = 1'b0;
        @(posedge clk);
        #1 check("flag_clear", 16'h0000, {15'h0000, high_byte_flag});
        iw = 2'h2;
        do_read(1'b0, remote_read_pkg::MS_INSTR, 8'h00);
        check("instr_wait", 16'h0002, {7'h00, hcyc - c0});
        check("instr_low2", 16'h003c, {8'h00, hdata});
        iw = 2'h0;
        do_read(1'b0, remote_read_pkg::MS_INSTR, 8'h00);
        check("instr_high", 16'h00a5, {8'h00, hdata});
        check("flag_toggle", 16'h0000, {15'h0000, high_byte_flag});
        check("pc_next", pc + remote_read_pkg::PC_STEP, pcnext);
        check("pc_increment", 16'h0001, {15'h0000, seen_inc});
        do_read(1'b0, remote_read_pkg::MS_DATA, 8'h00);
        c0 = hcyc;
        check("data_strobe", 16'h0001, {15'h0000, seen_rd});
        check("bus_float", 16'h0001, {15'h0000, seen_float});
        dw = 3'h3;
        do_read(1'b0, remote_read_pkg::MS_DATA, 8'h00);
        c1 = hcyc;
        check("data_wait", 16'h0003, {7'h00, c1 - c0});
        dw = 3'h0;
        do_read(1'b0, remote_read_pkg::MS_DATA, 8'd20);
        check("wait_extend", 16'h0001, {15'h0000, hcyc > 9'd21});
        lock_out_remote_bit = 1'b1;
        lreq = 1'b1;
        start_read(1'b0, remote_read_pkg::MS_PC_LOW, 8'h00);
        repeat (12) @(posedge clk);
        #1 check("ack_locked", 16'h0000, {15'h0000, ack});
        check("owner_locked", 16'h0000, {15'h0000, own_n});
        check("grant_hold", 16'h0001, {15'h0000, grant});
        lock_out_remote_bit = 1'b0;
        repeat (8) @(posedge clk);
        #1 check("owner_granted", 16'h0000, {15'h0000, own_n});
        lreq = 1'b0;
        // owner is looked at settled, just after each edge
        for (int n = 0; n < 20 && own_n !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        lreq = 1'b1;
        repeat (2) @(posedge clk);
        #1 check("stall_local", 16'h0001, {15'h0000, twait});
        finish_read();
        check("grant_after", 16'h0001, {15'h0000, grant});
        check("pc_low_late", {8'h00, pc[7:0]}, {8'h00, hdata});
        stop_test();
    end
endmodule : testbench
